/* File: core/lcc_pkg.sv */
// constants, types and register map of the lin control configuration block
// ----------------------------------------------------------------------------
// Functional notes
// - override bit set gives software direct control of the lin output line.
// - sync start bit accepted only if low below 8872 or 1209 counts.
// - sync start low reaching the limit is treated as a second break.
// - after reclassifying, keep counting low and compare with break minimum register.
// - transmit one stop bit when stop count bit is zero, two when one.
// - checksum bit zero gives enhanced checksum with pid, one gives classic.
// - direction bit clears on received break and on transmit complete.
// - direction bit also clears when software writes enable to zero.
// - direction one transmits response after pid decode, else receives.
// - interface works only while enabled; writing zero disables and resets it.
// - disable resets all state except preserved control bits, status bits, break minimum register and override level.
// ----------------------------------------------------------------------------
package lcc_pkg;

  // ----------------------------------------------------------------------------
  // register map, word aligned byte addresses
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  ADR_CONTROL   = 8'h00;
  localparam logic [7:0]  ADR_STATUS    = 8'h04;
  localparam logic [7:0]  ADR_BREAK_MIN = 8'h08;
  localparam logic [7:0]  ADR_OVERRIDE  = 8'h0C;

  // control field positions
  localparam int          BIT_ENABLE    = 0;
  localparam int          BIT_DIRECTION = 1;
  localparam int          BIT_CHECKSUM  = 2;
  localparam int          BIT_STOP      = 3;
  localparam int          BIT_SYNC_LIM  = 4;
  localparam int          BIT_OVERRIDE  = 6;

  // control bits that survive a disable write
  localparam logic [15:0] CTRL_KEEP     = 16'hB180;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;

  // status field positions (sticky, write one to clear)
  localparam int          ST_BREAK      = 0;
  localparam int          ST_SYNC_OK    = 1;
  localparam int          ST_REBREAK    = 2;
  localparam int          ST_TX_DONE    = 3;

  // sync start limits in peripheral clock counts
  localparam logic [19:0] SYNC_LIM_SLOW = 20'h0_22A8;  // 8872
  localparam logic [19:0] SYNC_LIM_FAST = 20'h0_04B9;  // 1209
  localparam logic [19:0] BREAK_MIN_RST = 20'h0_8000;
  localparam logic [19:0] COUNT_MAX     = 20'hF_FFFF;

  typedef enum logic [2:0] {
    LCC_IDLE, LCC_BREAK_LOW, LCC_DELIM, LCC_SYNC_LOW
  } lcc_det_e;

  // one byte offered to the checksum unit by the frame engine
  typedef struct packed {
    logic       valid;
    logic       is_pid;
    logic       first;
    logic [7:0] data;
  } lcc_byte_s;

endpackage

/* File: core/lcc_top.sv */
// lin control register with break/sync start timing, checksum and line drive
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module lcc_top
  import lcc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        lin_rx,
  input  wire logic        engine_tx,
  input  wire logic        pid_decoded,
  input  wire logic        tx_complete,
  input  wire lcc_byte_s   chk_in,
  output logic             lin_tx,
  output logic             stop_two,
  output logic             respond_tx,
  output logic             respond_rx,
  output logic             break_seen,
  output logic             sync_start_ok,
  output logic [7:0]       checksum,
  output logic             interface_on
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  logic [15:0] lin_control;
  logic [15:0] next_lin_control;
  logic [19:0] break_min_time_reg;
  logic [19:0] next_break_min_time_reg;
  logic        sw_level;
  logic        next_sw_level;
  logic [3:0]  link_status_reg;
  logic [3:0]  next_link_status_reg;
  logic        next_ack;
  logic [31:0] next_dat;
  lcc_det_e    det;
  lcc_det_e    next_det;
  logic [19:0] low_cnt;
  logic [19:0] next_low_cnt;
  logic        rx_q;
  logic        next_break_seen;
  logic        next_sync_ok;
  logic        rebreak;
  logic        next_rebreak;
  logic [8:0]  chk_sum;
  logic [8:0]  next_chk_sum;
  logic        next_lin_tx;
  logic        next_respond_tx;
  logic        next_respond_rx;

  logic        access;
  logic        wr_ctrl;
  logic        disabling;
  logic [15:0] wr_word;
  logic [19:0] sync_limit;
  logic        fall;
  logic        rise;
  logic [8:0]  add;

  // ----------------------------------------------------------------------------
  // bus decode: one wait state, ack registered so it drops the cycle after
  // ----------------------------------------------------------------------------
  assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl   = access && wb_we_i && (wb_adr_i == ADR_CONTROL);
  assign wr_word   = {wb_sel_i[1] ? wb_dat_i[15:8] : lin_control[15:8],
                      wb_sel_i[0] ? wb_dat_i[7:0]  : lin_control[7:0]};
  assign disabling = wr_ctrl && !wr_word[BIT_ENABLE];
  assign sync_limit = lin_control[BIT_SYNC_LIM] ? SYNC_LIM_FAST : SYNC_LIM_SLOW;
  assign fall      = rx_q && !lin_rx;
  assign rise      = !rx_q && lin_rx;

  // register writes and read mux
  always_comb begin
    next_ack                = access;
    next_dat                = 32'h0000_0000;
    next_lin_control        = lin_control;
    next_break_min_time_reg = break_min_time_reg;
    next_sw_level           = sw_level;
    if (wr_ctrl) begin
      next_lin_control = wr_word;
      if (disabling) begin
        // preserved bits keep what software wrote, the rest fall to reset
        next_lin_control = (wr_word & CTRL_KEEP) | (CTRL_RESET & ~CTRL_KEEP);
        next_lin_control[BIT_DIRECTION] = 1'b0;
      end
    end
    // hardware clear wins over a software set in the same cycle: the event is fresher
    if (break_seen || tx_complete) begin
      next_lin_control[BIT_DIRECTION] = 1'b0;
    end
    if (access && wb_we_i && wb_adr_i == ADR_BREAK_MIN) begin
      if (wb_sel_i[0]) next_break_min_time_reg[7:0]   = wb_dat_i[7:0];
      if (wb_sel_i[1]) next_break_min_time_reg[15:8]  = wb_dat_i[15:8];
      if (wb_sel_i[2]) next_break_min_time_reg[19:16] = wb_dat_i[19:16];
    end
    if (access && wb_we_i && wb_adr_i == ADR_OVERRIDE && wb_sel_i[0]) begin
      next_sw_level = wb_dat_i[0];
    end
    if (access && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CONTROL:   next_dat = {16'h0000, lin_control};
        ADR_STATUS:    next_dat = {16'h0000, checksum, 4'h0, link_status_reg};
        ADR_BREAK_MIN: next_dat = {12'h000, break_min_time_reg};
        ADR_OVERRIDE:  next_dat = {31'h0000_0000, sw_level};
        default:       next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wb_ack_o           <= 1'b0;
      wb_dat_o           <= 32'h0000_0000;
      lin_control        <= CTRL_RESET;
      break_min_time_reg <= BREAK_MIN_RST;
      sw_level           <= 1'b1;
    end else begin
      wb_ack_o           <= next_ack;
      wb_dat_o           <= next_dat;
      lin_control        <= next_lin_control;
      break_min_time_reg <= next_break_min_time_reg;
      sw_level           <= next_sw_level;
    end
  end

  // ----------------------------------------------------------------------------
  // sticky status: set beats a write-one clear; not touched by disable
  // ----------------------------------------------------------------------------
  always_comb begin
    next_link_status_reg = link_status_reg;
    if (access && wb_we_i && wb_adr_i == ADR_STATUS && wb_sel_i[0]) begin
      next_link_status_reg = link_status_reg & ~wb_dat_i[3:0];
    end
    if (break_seen)    next_link_status_reg[ST_BREAK]   = 1'b1;
    if (sync_start_ok) next_link_status_reg[ST_SYNC_OK] = 1'b1;
    if (rebreak)       next_link_status_reg[ST_REBREAK] = 1'b1;
    if (tx_complete)   next_link_status_reg[ST_TX_DONE] = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      link_status_reg <= 4'h0;
    end else begin
      link_status_reg <= next_link_status_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // break and sync start timer
  // ----------------------------------------------------------------------------
  // counter saturates so a stuck-low bus never wraps back into a short pulse
  always_comb begin
    next_det        = det;
    next_low_cnt    = low_cnt;
    next_break_seen = 1'b0;
    next_sync_ok    = 1'b0;
    next_rebreak    = 1'b0;
    if (low_cnt != COUNT_MAX) next_low_cnt = low_cnt + 20'h0_0001;
    case (det)
      LCC_IDLE: begin
        if (fall) begin
          next_det     = LCC_BREAK_LOW;
          next_low_cnt = 20'h0_0001;
        end
      end
      LCC_BREAK_LOW: begin
        // level, not edge: a release on the edge that reclassified the low has no rise left
        if (lin_rx) begin
          // count carried over from a reclassified sync start counts too
          if (low_cnt >= break_min_time_reg) begin
            next_break_seen = 1'b1;
            next_det        = LCC_DELIM;
          end else begin
            next_det = LCC_IDLE;
          end
        end
      end
      LCC_DELIM: begin
        if (fall) begin
          next_det     = LCC_SYNC_LOW;
          next_low_cnt = 20'h0_0001;
        end
      end
      LCC_SYNC_LOW: begin
        if (low_cnt >= sync_limit) begin
          next_det     = LCC_BREAK_LOW;
          next_rebreak = 1'b1;
          // released on this same edge: freeze the count so the break is not overmeasured
          if (lin_rx) next_low_cnt = low_cnt;
        end else if (rise) begin
          next_sync_ok = 1'b1;
          next_det     = LCC_IDLE;
        end
      end
      default: next_det = LCC_IDLE;
    endcase
    if (!interface_on || disabling) begin
      next_det     = LCC_IDLE;
      next_low_cnt = 20'h0_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      det           <= LCC_IDLE;
      low_cnt       <= 20'h0_0000;
      rx_q          <= 1'b1;
      break_seen    <= 1'b0;
      sync_start_ok <= 1'b0;
      rebreak       <= 1'b0;
    end else begin
      det           <= next_det;
      low_cnt       <= next_low_cnt;
      rx_q          <= lin_rx;
      break_seen    <= next_break_seen;
      sync_start_ok <= next_sync_ok;
      rebreak       <= next_rebreak;
    end
  end

  // ----------------------------------------------------------------------------
  // checksum: sum with end-around carry, inverted on output
  // ----------------------------------------------------------------------------
  assign add = {1'b0, chk_sum[7:0]} + {8'h00, chk_sum[8]} + {1'b0, chk_in.data};

  always_comb begin
    next_chk_sum = chk_sum;
    if (chk_in.valid && chk_in.first) begin
      next_chk_sum = 9'h000;
    end
    // classic mode skips the pid byte, enhanced mode folds it in
    if (chk_in.valid && !(chk_in.is_pid && lin_control[BIT_CHECKSUM])) begin
      next_chk_sum = chk_in.first ? {1'b0, chk_in.data} : add;
    end
    if (!interface_on) next_chk_sum = 9'h000;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      chk_sum  <= 9'h000;
      checksum <= 8'hFF;
    end else begin
      chk_sum  <= next_chk_sum;
      checksum <= ~(next_chk_sum[7:0] + {7'h00, next_chk_sum[8]});
    end
  end

  // ----------------------------------------------------------------------------
  // line drive and response direction
  // ----------------------------------------------------------------------------
  // a disabled interface leaves the line recessive; the disable write also clears the override bit
  always_comb begin
    next_lin_tx     = interface_on ? engine_tx : 1'b1;
    if (lin_control[BIT_OVERRIDE]) next_lin_tx = sw_level;
    next_respond_tx = interface_on && pid_decoded && lin_control[BIT_DIRECTION];
    next_respond_rx = interface_on && pid_decoded && !lin_control[BIT_DIRECTION];
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lin_tx       <= 1'b1;
      stop_two     <= 1'b0;
      respond_tx   <= 1'b0;
      respond_rx   <= 1'b0;
      interface_on <= 1'b0;
    end else begin
      lin_tx       <= next_lin_tx;
      stop_two     <= next_lin_control[BIT_STOP];
      respond_tx   <= next_respond_tx;
      respond_rx   <= next_respond_rx;
      interface_on <= next_lin_control[BIT_ENABLE];
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  a_override_drive: assert property (@(posedge mclk) disable iff (!rst_b)
    lin_control[BIT_OVERRIDE] |=> lin_tx == $past(sw_level))
    else $error("override level not on line");
  a_sync_accept: assert property (@(posedge mclk) disable iff (!rst_b)
    sync_start_ok |-> $past(low_cnt) < $past(sync_limit))
    else $error("sync start accepted past limit");
  a_rebreak_move: assert property (@(posedge mclk) disable iff (!rst_b)
    (det == LCC_SYNC_LOW && low_cnt >= sync_limit && interface_on && !disabling)
      |=> det == LCC_BREAK_LOW && rebreak)
    else $error("long sync start not reclassified");
  a_break_min: assert property (@(posedge mclk) disable iff (!rst_b)
    break_seen |-> $past(low_cnt) >= $past(break_min_time_reg))
    else $error("break shorter than minimum");
  a_stop_count: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_ctrl && !disabling) |=> stop_two == $past(wr_word[BIT_STOP]))
    else $error("stop count mismatch");
  a_dir_hw_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    (break_seen || tx_complete) |=> !lin_control[BIT_DIRECTION])
    else $error("direction not cleared by event");
  a_dir_disable: assert property (@(posedge mclk) disable iff (!rst_b)
    disabling |=> !lin_control[BIT_DIRECTION] && !lin_control[BIT_OVERRIDE] ##1 !interface_on)
    else $error("disable write left state");
  a_respond_dir: assert property (@(posedge mclk) disable iff (!rst_b)
    (pid_decoded && interface_on) |=> respond_tx == $past(lin_control[BIT_DIRECTION])
      && respond_rx != respond_tx)
    else $error("response direction wrong");
  a_off_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    !interface_on |=> det == LCC_IDLE && !respond_tx && !respond_rx)
    else $error("disabled interface active");

endmodule
`default_nettype wire

/* File: verification/lcc_line_model.sv */
// behavioural lin line partner: holds the bus dominant for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module lcc_line_model (
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [15:0] low_cycles,
  output logic             lin_rx
);
  // ----------------------------------------------------------------------------
  // dominant phase counter
  // ----------------------------------------------------------------------------
  logic [15:0] left;
  initial left = 16'h0000;
  // released bus floats back to recessive through the pull-up
  always @(posedge mclk) begin
    if (go) begin
      left <= low_cycles;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end
  assign lin_rx = (left == 16'h0000);
endmodule
`default_nettype wire

/* File: verification/lcc_top_bench.sv */
// self-checking bench for the lin control configuration block
`timescale 1ns/1ps
`default_nettype none
module lin_control_config_bench;
  import lcc_pkg::*;
  logic mclk, rst_b, cyc, stb, we, engine_tx, pid_decoded, tx_complete, go;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, wb_dat_o, q;
  logic [15:0] low_cycles;
  lcc_byte_s chk_in;
  logic wb_ack_o, lin_rx, lin_tx, stop_two, respond_tx, respond_rx;
  logic break_seen, sync_start_ok, interface_on;
  logic [7:0] checksum;
  int mismatches, cmp_count, brk_n, sync_n, rtx_n, rrx_n;

  lcc_top uut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .lin_rx(lin_rx), .engine_tx(engine_tx),
    .pid_decoded(pid_decoded), .tx_complete(tx_complete), .chk_in(chk_in),
    .lin_tx(lin_tx), .stop_two(stop_two), .respond_tx(respond_tx),
    .respond_rx(respond_rx), .break_seen(break_seen), .sync_start_ok(sync_start_ok),
    .checksum(checksum), .interface_on(interface_on));
  lcc_line_model line (.mclk(mclk), .go(go), .low_cycles(low_cycles), .lin_rx(lin_rx));

  // ----------------------------------------------------------------------------
  // clock, pulse counters, reporting
  // ----------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // count one-cycle pulses so scenarios can judge them after the fact
  always @(posedge mclk) begin
    brk_n  <= brk_n + int'(break_seen === 1'b1);
    sync_n <= sync_n + int'(sync_start_ok === 1'b1);
    rtx_n  <= rtx_n + int'(respond_tx === 1'b1);
    rrx_n  <= rrx_n + int'(respond_rx === 1'b1);
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // classic wishbone cycle; no latency assumed, only a bounded wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(name, exp, q);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // dominant phase of n cycles, then a recessive delimiter
  task automatic low(input int n);
    int k;
    k = 0;
    @(posedge mclk);
    go <= 1'b1; low_cycles <= 16'(n);
    @(posedge mclk);
    go <= 1'b0;
    do begin
      @(posedge mclk);
      k++;
    end while (lin_rx !== 1'b1 && k < 10000);
    if (k >= 10000) begin
      mismatches++;
      test_done();
    end
    idle(20);
  endtask
  task automatic send(input logic p, input logic f, input logic [7:0] d);
    @(posedge mclk);
    chk_in <= '{valid: 1'b1, is_pid: p, first: f, data: d};
    @(posedge mclk);
    chk_in <= '0;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    rd("control", ADR_CONTROL, {16'h0000, CTRL_RESET});
    rd("break min", ADR_BREAK_MIN, {12'h000, BREAK_MIN_RST});
    rd("override level", ADR_OVERRIDE, 32'h0000_0001);
    rd("unmapped", 8'h10, 32'h0000_0000);
    chk("idle lin_tx", 32'h1, {31'h0, lin_tx});
    chk("idle checksum", 32'hFF, {24'h0, checksum});
  endtask
  task automatic t_drive();
    wb(1'b1, ADR_CONTROL, 32'h0000_0009);
    idle(3);
    chk("engine drive", 32'h0, {31'h0, lin_tx});
    chk("two stop", 32'h1, {31'h0, stop_two});
    chk("on", 32'h1, {31'h0, interface_on});
    wb(1'b1, ADR_CONTROL, 32'h0000_0049);
    idle(3);
    chk("override high", 32'h1, {31'h0, lin_tx});
    wb(1'b1, ADR_OVERRIDE, 32'h0000_0000);
    engine_tx <= 1'b1;
    idle(3);
    chk("override low", 32'h0, {31'h0, lin_tx});
    wb(1'b1, ADR_CONTROL, 32'h0000_0001);
    idle(3);
    chk("one stop", 32'h0, {31'h0, stop_two});
  endtask
  task automatic t_direction();
    wb(1'b1, ADR_CONTROL, 32'h0000_0003);
    @(posedge mclk) pid_decoded <= 1'b1;
    @(posedge mclk) pid_decoded <= 1'b0;
    idle(3);
    chk("respond tx", 32'h1, rtx_n);
    @(posedge mclk) tx_complete <= 1'b1;
    @(posedge mclk) tx_complete <= 1'b0;
    rd("dir after tx", ADR_CONTROL, 32'h0000_0001);
    @(posedge mclk) pid_decoded <= 1'b1;
    @(posedge mclk) pid_decoded <= 1'b0;
    idle(3);
    chk("respond rx", 32'h1, rrx_n);
    chk("no tx", 32'h1, rtx_n);
  endtask
  task automatic t_line();
    wb(1'b1, ADR_BREAK_MIN, 32'h0000_0014);
    wb(1'b1, ADR_CONTROL, 32'h0000_0013);
    low(30);
    rd("dir after break", ADR_CONTROL, 32'h0000_0011);
    low(1208);
    chk("fast sync ok", 32'h1, sync_n);
    low(30);
    low(1209);
    chk("fast rebreak", 32'h3, brk_n);
    chk("fast no sync", 32'h1, sync_n);
    wb(1'b1, ADR_CONTROL, 32'h0000_0001);
    // the reclassified low ended as a break, so the next low is a sync start
    low(8871);
    chk("slow sync ok", 32'h2, sync_n);
    low(30);
    low(8872);
    chk("slow rebreak", 32'h5, brk_n);
    // a restarted count would fall short of the minimum here
    wb(1'b1, ADR_BREAK_MIN, 32'h0000_05DC);
    wb(1'b1, ADR_CONTROL, 32'h0000_0011);
    low(1600);
    low(1600);
    chk("long rebreak", 32'h7, brk_n);
    chk("sync total", 32'h2, sync_n);
    // break, sync ok, rebreak and tx done all flagged; no bytes summed yet
    rd("status", ADR_STATUS, 32'h0000_FF0F);
    wb(1'b1, ADR_STATUS, 32'h0000_000F);
    rd("status cleared", ADR_STATUS, 32'h0000_FF00);
  endtask
  task automatic t_checksum();
    send(1'b1, 1'b1, 8'hF0);
    send(1'b0, 1'b0, 8'h20);
    idle(2);
    chk("enhanced", 32'hEE, {24'h0, checksum});
    wb(1'b1, ADR_CONTROL, 32'h0000_0000);
    wb(1'b1, ADR_CONTROL, 32'h0000_0005);
    send(1'b0, 1'b1, 8'h20);
    send(1'b1, 1'b0, 8'hF0);
    send(1'b0, 1'b0, 8'h10);
    idle(2);
    chk("classic", 32'hCF, {24'h0, checksum});
  endtask
  task automatic t_disable();
    // engine asks for dominant so a recessive line proves the disable forced it
    engine_tx <= 1'b0;
    wb(1'b1, ADR_CONTROL, 32'h0000_0007);
    wb(1'b1, ADR_CONTROL, 32'h0000_B186);
    rd("disable keep", ADR_CONTROL, 32'h0000_B180);
    chk("off", 32'h0, {31'h0, interface_on});
    chk("off drive", 32'h1, {31'h0, lin_tx});
    low(30);
    chk("off line", 32'h7, brk_n);
    wb(1'b1, ADR_CONTROL, 32'h0000_0003);
    // direction written high together with enable low must still read back zero
    wb(1'b1, ADR_CONTROL, 32'h0000_0002);
    rd("dir on disable", ADR_CONTROL, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    mismatches = 0; cmp_count = 0; brk_n = 0; sync_n = 0; rtx_n = 0; rrx_n = 0;
    rst_b = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hF;
    wdat = 32'h0000_0000; engine_tx = 1'b0; pid_decoded = 1'b0; tx_complete = 1'b0;
    go = 1'b0; low_cycles = 16'h0000; chk_in = '0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_drive();
    t_direction();
    t_line();
    t_checksum();
    t_disable();
    test_done();
  end
endmodule
`default_nettype wire
